/* common/defect_cmd_defs.vh */
// Constants for the defect-management command decoder.
`ifndef DEFECT_CMD_DEFS_VH
`define DEFECT_CMD_DEFS_VH
// Register byte offsets.
`define REG_CMD_LO 12'h000
`define REG_CMD_MID 12'h004
`define REG_CMD_HI 12'h008
`define REG_CTRL 12'h00C
`define REG_STATUS 12'h010
`define REG_SENSE 12'h014
`define REG_DESC_LO 12'h018
`define REG_DESC_HI 12'h01C
`define REG_LIMITS 12'h020
`define REG_SPARES 12'h024
`define REG_DATA 12'h028
`define REG_GROWN 12'h02C
// Operation codes.
`define OP_READ_LONG_VU 8'hE8
`define OP_READ_LONG_S2 8'h3E
`define OP_REASSIGN 8'h07
`define OP_RECV_DIAG 8'h1C
`define OP_SEND_DIAG 8'h1D
`define OP_READ_DEFECT 8'h37
// Defect list formats.
`define FMT_INDEX 3'h4
`define FMT_PHYS 3'h5
// Sense keys and error codes.
`define KEY_NONE 4'h0
`define KEY_MEDIUM 4'h3
`define KEY_ILLEGAL 4'h5
`define ERR_NONE 8'h00
`define ERR_INV_CMD 8'h20
`define ERR_BAD_LBA 8'h21
`define ERR_INV_FIELD 8'h24
`define ERR_NO_SPARE 8'h32
// Long read size.
`define ECC_BYTES 16'h0006
`define PHYS_SECTOR_DEF 16'h0200
// Control bits.
`define CTRL_GO 0
`define CTRL_SENSE_CLR 1
`endif

/* core/defect_cmd_decoder.v */
// Defect-management and long-read command decoder with an APB slave.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "defect_cmd_defs.vh"
// Function
// - Physical-sector list header format is 05h.
// - Descriptor: cylinder3, head1, sector4, MSB first.
// - Other list formats: illegal request 05h/24h.
// - Long read sends one block plus ECC.
// - Long read data passes uncorrected.
// - E8h and 3Eh both decode as long read.
// - Bytes seven and eight ignored; one sector.
// - Correction request bit causes no correction.
// - Ten-byte block: address bytes two to five.
// - Location uses physical sector size.
// - Bad long read address: 05h/21h.
// - Reassign moves listed blocks to spares.
// - Unlisted blocks keep their data.
// - Successful reassign adds grown list entry.
// - Header bytes two, three give descriptor bytes.
// - Zero descriptor count is not an error.
// - Too few spares: medium error 03h/32h.
// - Invalid listed address: 05h/21h.
// - Receive diagnostic results is unsupported.
// - Without prior send diagnostic: 05h/20h.
// - Bytes-from-index list header format is 04h.
module defect_cmd_decoder (
    // APB clock and reset.
    input wire pclk,
    input wire presetn,
    // APB request.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // APB answer.
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Medium location request for the datapath.
    output reg [31:0] phys_byte_addr,
    output reg medium_go,
    output reg check_condition,
    output reg cmd_done
);

    // State codes, one-hot.
    localparam S_IDLE = 4'h1;
    localparam S_EXEC = 4'h2;
    localparam S_LIST = 4'h4;
    localparam S_END = 4'h8;

    // Command block bytes held by software writes.
    reg [31:0] cmd_lo;
    reg [31:0] cmd_mid;
    reg [15:0] cmd_hi;
    // Block limit and spare count set by firmware.
    reg [31:0] max_lba;
    reg [15:0] spares;
    // Physical sector size in bytes.
    reg [15:0] phys_size;
    // Held sense key and error code.
    reg [3:0] sense_key;
    reg [7:0] sense_code;
    // Command state.
    reg [3:0] state;
    // Set once a send diagnostic command was seen.
    reg diag_sent;
    // Reassign parameter stream bookkeeping.
    reg [15:0] list_left;
    reg [1:0] hdr_cnt;
    reg [1:0] byte_cnt;
    reg [31:0] lba_acc;
    reg [15:0] grown_cnt;
    reg reassign_bad;
    reg spare_short;
    // Set once the four header bytes of the list are in, so that the
    // fourth header byte is never taken for a descriptor byte.
    reg hdr_done;
    // Defect descriptor to be returned, packed in eight bytes.
    reg [23:0] desc_cyl;
    reg [7:0] desc_head;
    reg [31:0] desc_sect;
    reg [2:0] list_fmt;
    // Long read transfer length, block plus ECC.
    reg [15:0] xfer_len;

    // Aliases for the command block fields.
    wire [7:0] opcode = cmd_lo[7:0];
    wire [31:0] cdb_lba = {cmd_lo[23:16], cmd_lo[31:24],
                           cmd_mid[7:0], cmd_mid[15:8]};
    wire [2:0] req_fmt = cmd_lo[18:16];
    wire [15:0] diag_alloc = {cmd_lo[31:24], cmd_mid[7:0]};

    // APB strobes. A write lands only at the edge at which the access
    // phase meets pready high, so the master and this block agree on
    // the edge at which a register changes. Read data is latched one
    // edge earlier so that it already stands when pready is sampled.
    wire wr_en = psel & penable & pwrite & pready;
    wire rd_en = psel & penable & ~pwrite & ~pready;

    // Returns true when an opcode means a long read. Both the vendor
    // code and the later standard code run the same path, so a host
    // written for either form sees identical behaviour.
    function is_long_read;
        input [7:0] op;
        begin
            is_long_read = (op == `OP_READ_LONG_VU) |
                           (op == `OP_READ_LONG_S2);
        end
    endfunction

    // Known register offsets. Anything past the last register or off
    // a word boundary is answered with an error on pslverr.
    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a <= `REG_GROWN) & (a[1:0] == 2'b00);
        end
    endfunction

    // Read data mux. It is combinational on the address and is only
    // latched into prdata in the first access cycle of a read, which
    // keeps prdata steady while the master waits for pready.
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `REG_CMD_LO: next_prdata = cmd_lo;
            `REG_CMD_MID: next_prdata = cmd_mid;
            `REG_CMD_HI: next_prdata = {16'h0000, cmd_hi};
            `REG_STATUS: next_prdata = {diag_sent, 11'h000, xfer_len,
                                        state};
            // Held sense data for a later sense request.
            `REG_SENSE: next_prdata = {20'h00000, sense_key,
                                       sense_code};
            // Descriptor: cylinder then head, MSB first.
            `REG_DESC_LO: next_prdata = {desc_cyl, desc_head};
            `REG_DESC_HI: next_prdata = desc_sect;
            `REG_LIMITS: next_prdata = max_lba;
            `REG_SPARES: next_prdata = {phys_size, spares};
            `REG_GROWN: next_prdata = {13'h0000, list_fmt, grown_cnt};
            default: next_prdata = 32'h00000000;
        endcase
    end

    // APB handshake: one wait state, answer on the second access cycle.
    // pready is high for exactly one cycle per transfer, because it is
    // only raised while it is low; pslverr stands beside it.
    // The master must hold the request until it sees pready high.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    // Command engine. Software loads the command block through the
    // register bus, then writes the go bit. The block is decoded in
    // one cycle; a reassignment stays in the list state until a
    // second go write closes the parameter list. Every command ends
    // with a one-cycle cmd_done pulse.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_lo <= 32'h00000000;
            cmd_mid <= 32'h00000000;
            cmd_hi <= 16'h0000;
            max_lba <= 32'h0000FFFF;
            spares <= 16'h0010;
            phys_size <= `PHYS_SECTOR_DEF;
            sense_key <= `KEY_NONE;
            sense_code <= `ERR_NONE;
            state <= S_IDLE;
            diag_sent <= 1'b0;
            list_left <= 16'h0000;
            hdr_cnt <= 2'h0;
            byte_cnt <= 2'h0;
            lba_acc <= 32'h00000000;
            grown_cnt <= 16'h0000;
            reassign_bad <= 1'b0;
            spare_short <= 1'b0;
            hdr_done <= 1'b0;
            desc_cyl <= 24'h000000;
            desc_head <= 8'h00;
            desc_sect <= 32'h00000000;
            list_fmt <= 3'h0;
            xfer_len <= 16'h0000;
            phys_byte_addr <= 32'h00000000;
            medium_go <= 1'b0;
            check_condition <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            medium_go <= 1'b0;
            cmd_done <= 1'b0;
            case (state)
                // Waiting for software to load a block and start it.
                S_IDLE: begin
                    if (wr_en) begin
                        case (paddr)
                            `REG_CMD_LO: cmd_lo <= pwdata;
                            `REG_CMD_MID: cmd_mid <= pwdata;
                            `REG_CMD_HI: cmd_hi <= pwdata[15:0];
                            `REG_LIMITS: max_lba <= pwdata;
                            `REG_SPARES: begin
                                spares <= pwdata[15:0];
                                phys_size <= pwdata[31:16];
                            end
                            // Defect entry staged for return.
                            `REG_DESC_LO: begin
                                desc_cyl <= pwdata[31:8];
                                desc_head <= pwdata[7:0];
                            end
                            `REG_DESC_HI: desc_sect <= pwdata;
                            `REG_CTRL: begin
                                if (pwdata[`CTRL_SENSE_CLR]) begin
                                    sense_key <= `KEY_NONE;
                                    sense_code <= `ERR_NONE;
                                    check_condition <= 1'b0;
                                end
                                if (pwdata[`CTRL_GO]) begin
                                    state <= S_EXEC;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                // Decode the command block.
                S_EXEC: begin
                    state <= S_END;
                    check_condition <= 1'b0;
                    if (is_long_read(opcode)) begin
                        // Bytes 6..8 and the correction bit are not read.
                        if (cdb_lba > max_lba) begin
                            sense_key <= `KEY_ILLEGAL;
                            sense_code <= `ERR_BAD_LBA;
                            check_condition <= 1'b1;
                        end else begin
                            // One sector plus ECC; no correction stage.
                            xfer_len <= phys_size + `ECC_BYTES;
                            phys_byte_addr <= cdb_lba *
                                {16'h0000, phys_size};
                            medium_go <= 1'b1;
                        end
                    end else if (opcode == `OP_READ_DEFECT) begin
                        if (req_fmt == `FMT_PHYS) begin
                            list_fmt <= `FMT_PHYS;
                        end else if (req_fmt == `FMT_INDEX) begin
                            list_fmt <= `FMT_INDEX;
                        end else begin
                            sense_key <= `KEY_ILLEGAL;
                            sense_code <= `ERR_INV_FIELD;
                            check_condition <= 1'b1;
                        end
                    end else if (opcode == `OP_REASSIGN) begin
                        hdr_cnt <= 2'h0;
                        byte_cnt <= 2'h0;
                        reassign_bad <= 1'b0;
                        spare_short <= 1'b0;
                        list_left <= 16'h0000;
                        // A new list always starts with its header.
                        hdr_done <= 1'b0;
                        state <= S_LIST;
                    end else if (opcode == `OP_SEND_DIAG) begin
                        diag_sent <= 1'b1;
                    end else if (opcode == `OP_RECV_DIAG) begin
                        // Unsupported; allocation length is recorded.
                        xfer_len <= diag_alloc;
                        sense_key <= `KEY_ILLEGAL;
                        sense_code <= diag_sent ? `ERR_INV_FIELD
                                                : `ERR_INV_CMD;
                        check_condition <= 1'b1;
                        diag_sent <= 1'b0;
                    end else begin
                        sense_key <= `KEY_ILLEGAL;
                        sense_code <= `ERR_INV_CMD;
                        check_condition <= 1'b1;
                    end
                end
                // Reassign parameter bytes arrive as writes to DATA.
                S_LIST: begin
                    if (wr_en && paddr == `REG_DATA) begin
                        if (!hdr_done) begin
                            // Four header bytes; bytes two and three
                            // carry the descriptor byte count.
                            hdr_cnt <= hdr_cnt + 2'h1;
                            if (hdr_cnt == 2'h2) begin
                                // Count, most significant byte.
                                list_left[15:8] <= pwdata[7:0];
                            end
                            if (hdr_cnt == 2'h3) begin
                                // Count, least significant byte.
                                list_left[7:0] <= pwdata[7:0];
                                hdr_done <= 1'b1;
                            end
                        end else if (list_left == 16'h0000) begin
                            // Bytes past the stated count are dropped, so
                            // an empty list moves nothing.
                            byte_cnt <= byte_cnt;
                        end else begin
                            // Descriptor bytes, MSB first.
                            lba_acc <= {lba_acc[23:0], pwdata[7:0]};
                            byte_cnt <= byte_cnt + 2'h1;
                            list_left <= list_left - 16'h0001;
                            // The fourth byte completes one address.
                            if (byte_cnt == 2'h3) begin
                                if ({lba_acc[23:0], pwdata[7:0]} >
                                    max_lba) begin
                                    // Address beyond the last block.
                                    reassign_bad <= 1'b1;
                                end else if (spares == 16'h0000) begin
                                    // No spare sector is left to use.
                                    spare_short <= 1'b1;
                                end else begin
                                    // Only this block moves to a spare.
                                    spares <= spares - 16'h0001;
                                    grown_cnt <= grown_cnt + 16'h0001;
                                end
                            end
                        end
                    end
                    // Software ends the list with a go write.
                    if (wr_en && paddr == `REG_CTRL &&
                        pwdata[`CTRL_GO]) begin
                        state <= S_END;
                        // Zero-length list finishes clean.
                        if (reassign_bad) begin
                            sense_key <= `KEY_ILLEGAL;
                            sense_code <= `ERR_BAD_LBA;
                            check_condition <= 1'b1;
                        end else if (spare_short) begin
                            sense_key <= `KEY_MEDIUM;
                            sense_code <= `ERR_NO_SPARE;
                            check_condition <= 1'b1;
                        end
                    end
                end
                // One-cycle completion pulse. The check flag stays until the next
                // command starts or software clears it; the held sense data stays
                // until software clears it or a later failing command overwrites it.
                S_END: begin
                    cmd_done <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule

/* bench/defect_cmd_props.sv */
// Port-level assertions for the defect command decoder.
`timescale 1ns/10ps
module defect_cmd_props (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB request.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // APB answer.
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Command results.
    input wire [31:0] phys_byte_addr,
    input wire medium_go,
    input wire check_condition,
    input wire cmd_done
);
    // All checks sample on the APB clock and pause in reset.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // An access phase in progress.
    sequence access_s;
        psel && penable;
    endsequence
    // A command that finished without a check condition.
    sequence done_ok_s;
        cmd_done && !check_condition;
    endsequence
    // A waiting access is answered at the next edge.
    ready_late_a: assert property (access_s ##0 !pready |=> pready)
        else $error("access not answered after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_err_a: assert property (access_s ##0 pready
        && (paddr > 12'h02C || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not flagged");
    done_pulse_a: assert property (cmd_done |=> !cmd_done)
        else $error("done pulse longer than one cycle");
    go_pulse_a: assert property (medium_go |=> !medium_go)
        else $error("medium start longer than one cycle");
    go_done_a: assert property (medium_go |-> ##[0:2] done_ok_s)
        else $error("accepted long read did not finish cleanly");
    go_align_a: assert property (medium_go |->
        phys_byte_addr[8:0] == 9'h000)
        else $error("location not a whole physical sector");
    check_done_a: assert property ($rose(check_condition)
        |-> ##[0:1] cmd_done)
        else $error("check raised without command end");
endmodule
bind defect_cmd_decoder defect_cmd_props i_defect_cmd_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phys_byte_addr(phys_byte_addr),
    .medium_go(medium_go), .check_condition(check_condition),
    .cmd_done(cmd_done));

/* bench/scsi_initiator_model.sv */
// Initiator model that reaches the decoder as an APB master.
`timescale 1ns/10ps
`include "defect_cmd_defs.vh"
module scsi_initiator_model (
    // Clock.
    input wire pclk,
    // APB request.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // APB answer.
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    // The bus is idle from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // One transfer; request held until ready is sampled high.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Sends a reassign list of n ascending addresses, a byte at a time.
    task send_list(input int n, input logic [31:0] lba0);
        logic [31:0] r;
        logic [31:0] lba;
        logic [15:0] cnt;
        logic e;
        cnt = 16'(4 * n);
        xfer(1'b1, `REG_DATA, 32'h00000000, r, e);
        xfer(1'b1, `REG_DATA, 32'h00000000, r, e);
        xfer(1'b1, `REG_DATA, {24'h000000, cnt[15:8]}, r, e);
        xfer(1'b1, `REG_DATA, {24'h000000, cnt[7:0]}, r, e);
        for (int i = 0; i < n; i++) begin
            lba = lba0 + 32'(3 * i);
            for (int b = 3; b >= 0; b--) begin
                xfer(1'b1, `REG_DATA, {24'h000000, lba[8*b +: 8]}, r, e);
            end
        end
    endtask
endmodule

/* bench/scsi_defect_cmd_decoder_tb.sv */
// Self-checking testbench for the defect command decoder.
`timescale 1ns/10ps
`include "defect_cmd_defs.vh"
module scsi_defect_cmd_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
    logic medium_go, check_condition, cmd_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, phys_byte_addr, rv, g0;
    int bad_count = 0;
    int n_tests = 0;
    int done_cnt = 0;
    int go_cnt = 0;
    // Free-running 20 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Counts the done and medium start pulses.
    always @(posedge pclk) begin
        if (cmd_done === 1'b1) done_cnt++;
        if (medium_go === 1'b1) go_cnt++;
    end
    defect_cmd_decoder i_defect_cmd_decoder (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phys_byte_addr(phys_byte_addr),
        .medium_go(medium_go), .check_condition(check_condition),
        .cmd_done(cmd_done));
    scsi_initiator_model i_scsi_initiator_model (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Compares one value and reports a mismatch.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        i_scsi_initiator_model.xfer(1'b1, a, d, rv, ev);
    endtask
    task rd(input logic [11:0] a);
        i_scsi_initiator_model.xfer(1'b0, a, 32'h00000000, rv, ev);
    endtask
    // Loads a command block, starts it and waits for its end.
    task run(input logic [31:0] lo, mid, hi, input int n, lba0);
        int c;
        c = done_cnt;
        wr(`REG_CMD_LO, lo);
        wr(`REG_CMD_MID, mid);
        wr(`REG_CMD_HI, hi);
        wr(`REG_CTRL, 32'h00000001);
        if (lo[7:0] == `OP_REASSIGN) begin
            i_scsi_initiator_model.send_list(n, lba0);
            wr(`REG_CTRL, 32'h00000001);
        end
        repeat (40) if (done_cnt == c) @(posedge pclk);
        check({31'h0, done_cnt != c}, 32'h1);
    endtask
    task sense_is(input logic [31:0] exp);
        rd(`REG_SENSE);
        check(rv, exp);
        wr(`REG_CTRL, 32'h00000002);
    endtask
    task t_reset;
        check({31'h0, check_condition}, 32'h0);
        rd(`REG_LIMITS);
        check(rv, 32'h0000FFFF);
        rd(12'h030);
        check({31'h0, ev}, 32'h1);
        $display("test reset done");
    endtask
    // Both opcodes, correction bit set, junk in bytes seven and eight.
    task t_long_read;
        int g;
        for (int i = 0; i < 2; i++) begin
            g = go_cnt;
            run({16'h0000, 8'h02, i ? `OP_READ_LONG_S2 : `OP_READ_LONG_VU},
                32'h05001200, 32'h00000003, 0, 0);
            check(32'(go_cnt - g), 32'h1);
            check(phys_byte_addr, 32'h12 * `PHYS_SECTOR_DEF);
            check({31'h0, check_condition}, 32'h0);
            rd(`REG_STATUS);
            check(32'(rv[19:4]), 32'(`PHYS_SECTOR_DEF + `ECC_BYTES));
        end
        $display("test long read done");
    endtask
    // Bad address, then a good command keeps the sense until cleared.
    task t_bad_lba;
        run({8'h01, 16'h0000, `OP_READ_LONG_VU}, 0, 0, 0, 0);
        check({31'h0, check_condition}, 32'h1);
        rd(`REG_SENSE);
        check(rv, 32'h00000521);
        run({16'h0000, 8'h00, `OP_READ_LONG_VU}, 32'h00001200, 0, 0, 0);
        sense_is(32'h00000521);
        rd(`REG_SENSE);
        check(rv, 32'h00000000);
        $display("test bad address done");
    endtask
    task t_defect;
        for (logic [2:0] f = 3'h4; f <= 3'h6; f++) begin
            run({8'h00, 5'h03, f, 8'h00, `OP_READ_DEFECT}, 0, 0, 0, 0);
            if (f == 3'h6) sense_is(32'h00000524);
            else begin
                rd(`REG_GROWN);
                check({29'h0, rv[18:16]}, {29'h0, f});
            end
        end
        run({24'h000000, `OP_RECV_DIAG}, 32'h00000010, 0, 0, 0);
        sense_is(32'h00000520);
        run({24'h000000, `OP_SEND_DIAG}, 0, 0, 0, 0);
        run({24'h000000, `OP_RECV_DIAG}, 32'h00000010, 0, 0, 0);
        sense_is(32'h00000524);
        $display("test defect list and diagnostics done");
    endtask
    task t_reassign;
        rd(`REG_GROWN);
        g0 = rv;
        run({24'h000000, `OP_REASSIGN}, 0, 0, 2, 32'h5);
        check({31'h0, check_condition}, 32'h0);
        rd(`REG_GROWN);
        check({31'h0, rv[15:0] > g0[15:0]}, 32'h1);
        run({24'h000000, `OP_REASSIGN}, 0, 0, 0, 0);
        check({31'h0, check_condition}, 32'h0);
        run({24'h000000, `OP_REASSIGN}, 0, 0, 1, 32'h00020000);
        sense_is(32'h00000521);
        run({24'h000000, `OP_REASSIGN}, 0, 0, 16, 32'h100);
        sense_is(32'h00000332);
        $display("test reassign done");
    endtask
    // Reset for four cycles, then the tests in turn.
    initial begin
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_long_read;
        t_bad_lba;
        t_defect;
        t_reassign;
        give_verdict;
    end
    // Cuts a hang short well after the tests should have ended.
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        give_verdict;
    end
endmodule
